// ### general_purpose_timer_unit_test.sv
// testbench for gtu_top: apb register sequences with pin events
// assumes gtu_pins drives the pins and gtu_monitor is bound to the design
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_unit_test;
  import gtu_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  timer_in_pin, dir_in_pin;
  logic [10:0] flip;
  logic        capture_input_pin, core_toggle_output, master_toggle_output;
  logic        capcom_clk_en, irq;
  int          mismatches, checked;
  ////////////////////////////////////////////////////////////////////////////////
  gtu_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer_in_pin(timer_in_pin), .dir_in_pin(dir_in_pin),
    .capture_input_pin(capture_input_pin), .core_toggle_output(core_toggle_output),
    .master_toggle_output(master_toggle_output), .capcom_clk_en(capcom_clk_en),
    .irq(irq));
  gtu_pins pins_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .flip(flip),
    .timer_in_pin(timer_in_pin), .dir_in_pin(dir_in_pin),
    .capture_input_pin(capture_input_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, counts and end of run
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin mismatches++; give_verdict(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin @(posedge clk_sys); n++; end
    chk({31'h0, irq}, 32'h1);
  endtask
  // one pin inversion, then time for the pin synchroniser
  task automatic tog(input logic [10:0] m);
    flip <= m;
    @(posedge clk_sys);
    flip <= 11'h000;
    repeat (5) @(posedge clk_sys);
  endtask
  // control word: flags give run 0x1, down 0x2, rise 0x200, gate 0x800, clear 0x1000
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [31:0] f);
    logic [31:0] r;
    r = f;
    r[CTL_MODE_L+:3] = m;
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // main sequence
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; flip = 11'h000; mismatches = 0; checked = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 11; i++) rdchk(8'(4 * i), 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3F);
    // core counts up through its maximum, then down through zero
    apb(1'b1, OFS_CORE_CNT, 32'hFFFE);
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_TIMER, 32'h10001));
    wait_irq();
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_TIMER, 32'h10000));
    rdchk(OFS_IRQ_STATUS, 32'h1);
    rdchk(OFS_LATCH, 32'h1);
    chk({31'h0, core_toggle_output}, 32'h1);
    apb(1'b0, OFS_CORE_CNT, 32'h0);
    rng(rd, 32'h0, 32'h10);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    rdchk(OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, OFS_CORE_CNT, 32'h1);
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_TIMER, 32'h3));
    wait_irq();
    apb(1'b1, OFS_CORE_CTRL, 32'h0);
    apb(1'b0, OFS_CORE_CNT, 32'h0);
    rng(rd, 32'hFFF0, 32'hFFFF);
    rdchk(OFS_LATCH, 32'h0);
    apb(1'b1, OFS_IRQ_STATUS, 32'h3F);
    // counter mode: five rising edges on the core pin
    apb(1'b1, OFS_CORE_CNT, 32'h0);
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_COUNTER, 32'h201));
    repeat (10) tog(11'h001);
    rdchk(OFS_CORE_CNT, 32'h5);
    // gated mode: no count while the gate is low, counts while high
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_GATED, 32'h801));
    repeat (40) @(posedge clk_sys);
    rdchk(OFS_CORE_CNT, 32'h5);
    tog(11'h001);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, OFS_CORE_CTRL, 32'h0);
    apb(1'b0, OFS_CORE_CNT, 32'h0);
    rng(rd, 32'hE, 32'h14);
    tog(11'h001);
    // lower aux captures the stopped core value and then stands still
    apb(1'b1, OFS_CORE_CNT, 32'h1234);
    apb(1'b1, OFS_LAUX_CTRL, cw(MODE_CAPTURE, 32'h201));
    tog(11'h002);
    repeat (30) @(posedge clk_sys);
    rdchk(OFS_LAUX_CNT, 32'h1234);
    rdchk(OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, OFS_IRQ_STATUS, 32'h3F);
    // capture pin latches capture base, then clears it
    apb(1'b1, OFS_CBASE_CNT, 32'h0ABC);
    apb(1'b1, OFS_CBASE_CTRL, cw(MODE_TIMER, 32'h1200));
    tog(11'h400);
    rdchk(OFS_CAPTURE_RELOAD_REG, 32'h0ABC);
    rdchk(OFS_CBASE_CNT, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h20);
    apb(1'b1, OFS_IRQ_STATUS, 32'h3F);
    // incremental: a edge then b edge, both count up
    apb(1'b1, OFS_CORE_CNT, 32'h0);
    apb(1'b1, OFS_CORE_CTRL, cw(MODE_INCR, 32'h1));
    tog(11'h001);
    tog(11'h020);
    rdchk(OFS_CORE_CNT, 32'h2);
    // upper aux reloads the stopped core on its pin
    apb(1'b1, OFS_CORE_CTRL, 32'h0);
    apb(1'b1, OFS_UAUX_CNT, 32'h55);
    apb(1'b1, OFS_UAUX_CTRL, cw(MODE_RELOAD, 32'h200));
    tog(11'h004);
    rdchk(OFS_CORE_CNT, 32'h55);
    // master: one count per two clocks, then a wrap with its status bit and latch
    apb(1'b1, OFS_MAST_CNT, 32'hFF00);
    apb(1'b1, OFS_MAST_CTRL, cw(MODE_TIMER, 32'h1));
    repeat (200) @(posedge clk_sys);
    apb(1'b1, OFS_MAST_CTRL, 32'h0);
    apb(1'b0, OFS_MAST_CNT, 32'h0);
    rng(rd, 32'hFF60, 32'hFF68);
    apb(1'b1, OFS_MAST_CNT, 32'hFFFE);
    apb(1'b1, OFS_MAST_CTRL, cw(MODE_TIMER, 32'h10001));
    wait_irq();
    apb(1'b1, OFS_MAST_CTRL, 32'h10000);
    rdchk(OFS_IRQ_STATUS, 32'h10);
    rdchk(OFS_LATCH, 32'h2);
    chk({31'h0, master_toggle_output}, 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule // general_purpose_timer_unit_test
`default_nettype wire

// ### gtu_monitor.sv
// checker for the timer unit ports: apb answer, errors, irq masking, latch pins
// assumes it is bound to gtu_top and sees only its ports, all on clk_sys
`timescale 1ns/1ps
`default_nettype none
module gtu_monitor
  import gtu_pkg::*;
(
  input wire logic        clk_sys,              // clock
  input wire logic        sys_rst,              // reset, high
  input wire logic        psel,                 // apb select
  input wire logic        penable,              // apb enable
  input wire logic        pwrite,               // apb direction
  input wire logic [7:0]  paddr,                // apb address
  input wire logic [31:0] pwdata,               // apb write data
  input wire logic        pready,               // apb ready
  input wire logic [31:0] prdata,               // apb read data
  input wire logic        pslverr,              // apb error
  input wire logic [4:0]  timer_in_pin,         // timer pins
  input wire logic [4:0]  dir_in_pin,           // direction pins
  input wire logic        capture_input_pin,    // capture pin
  input wire logic        core_toggle_output,   // core latch pin
  input wire logic        master_toggle_output, // master latch pin
  input wire logic        capcom_clk_en,        // master wrap pulse
  input wire logic        irq                   // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // decoded request phases
  logic setup, wr_acc, bad_adr, wr_q;
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign bad_adr = (paddr > OFS_LATCH) || (paddr[1:0] != 2'h0);
  // remembers a write one cycle back, it may legally move the latch pins
  always_ff @(posedge clk_sys) begin
    wr_q <= sys_rst ? 1'b0 : wr_acc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_answer: assert property (setup |=> pready)
    else $error("no ready in access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  a_unmapped_err: assert property (setup && bad_adr |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && !bad_adr |=> !pslverr)
    else $error("mapped access refused");
  a_capcom_pulse: assert property (capcom_clk_en |=> !capcom_clk_en)
    else $error("master wrap pulse too long or too fast");
  a_core_rate: assert property ($changed(core_toggle_output) && !wr_q
    |=> $stable(core_toggle_output) || wr_q)
    else $error("core latch toggles faster than finest step");
  a_master_latch: assert property ($changed(master_toggle_output)
    |-> capcom_clk_en || $past(capcom_clk_en) || wr_q || $past(wr_q))
    else $error("master latch moved without a wrap");
  a_irq_masked: assert property (wr_acc && paddr == OFS_IRQ_MASK && pwdata == 32'h0
    |-> ##2 !irq)
    else $error("irq high with all sources masked");
  c_irq: cover property (irq);
  c_capcom: cover property (capcom_clk_en);
  c_refused: cover property (pready && pslverr);
endmodule // gtu_monitor
bind gtu_top gtu_monitor mon_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .timer_in_pin(timer_in_pin),
  .dir_in_pin(dir_in_pin), .capture_input_pin(capture_input_pin),
  .core_toggle_output(core_toggle_output), .master_toggle_output(master_toggle_output),
  .capcom_clk_en(capcom_clk_en), .irq(irq));
`default_nettype wire

// ### gtu_pins.sv
// sensor and event pins outside the timer unit
// assumes the bench asks for one pin inversion at a time, held for some cycles
`timescale 1ns/1ps
`default_nettype none
module gtu_pins (
  input  wire logic        clk_sys,           // clock
  input  wire logic        sys_rst,           // reset, high
  input  wire logic [10:0] flip,              // pins to invert at next edge
  output logic      [4:0]  timer_in_pin,      // timer input pins
  output logic      [4:0]  dir_in_pin,        // direction pins
  output logic             capture_input_pin  // capture pin
);
  // each pin holds its level until asked to invert, low after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {capture_input_pin, dir_in_pin, timer_in_pin} <= 11'h000;
    end else begin
      {capture_input_pin, dir_in_pin, timer_in_pin} <=
        {capture_input_pin, dir_in_pin, timer_in_pin} ^ flip;
    end
  end
endmodule // gtu_pins
`default_nettype wire

// ### gtu_pkg.sv
// package for the general timer unit: register map, field layout, modes
// assumes a 32-bit apb slave on a single 250 mhz system clock
package gtu_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CORE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LAUX_CTRL   = 8'h04;
  localparam logic [7:0] OFS_UAUX_CTRL   = 8'h08;
  localparam logic [7:0] OFS_CBASE_CTRL  = 8'h0C;
  localparam logic [7:0] OFS_MAST_CTRL   = 8'h10;
  localparam logic [7:0] OFS_CORE_CNT    = 8'h14;
  localparam logic [7:0] OFS_LAUX_CNT    = 8'h18;
  localparam logic [7:0] OFS_UAUX_CNT    = 8'h1C;
  localparam logic [7:0] OFS_CBASE_CNT   = 8'h20;
  localparam logic [7:0] OFS_MAST_CNT    = 8'h24;
  localparam logic [7:0] OFS_CAPTURE_RELOAD_REG      = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h30;
  localparam logic [7:0] OFS_LATCH       = 8'h34;

  // control word fields
  localparam int CTL_RUN    = 0;  // timer runs
  localparam int CTL_DOWN   = 1;  // software count direction
  localparam int CTL_EXTDIR = 2;  // direction pin may invert direction
  localparam int CTL_MODE_L = 3;  // 3 bits of mode
  localparam int CTL_PRE_L  = 6;  // 3 bits prescaler exponent
  localparam int CTL_EDGE_L = 9;  // 2 bits: trigger edge select (rise, fall)
  localparam int CTL_GATEHI = 11; // gate level for gated mode
  localparam int CTL_CLRCB  = 12; // capture base: clear after capture
  localparam int CTL_CAPSRC = 13; // capture base: 2 bits, core in / core dir
  localparam int CTL_RLTOG  = 15; // master: reload on over/underflow
  localparam int CTL_OUTEN  = 16; // toggle latch drives its output pin

  // mode encodings
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_GATED   = 3'h1;
  localparam logic [2:0] MODE_COUNTER = 3'h2;
  localparam logic [2:0] MODE_INCR    = 3'h3;
  localparam logic [2:0] MODE_RELOAD  = 3'h4; // aux timers only
  localparam logic [2:0] MODE_CAPTURE = 3'h5; // aux timers only
  localparam logic [2:0] MODE_LATCHCK = 3'h6; // clocked by other toggle latch

  // base prescaler steps
  localparam int FIRST_GRP_BASE  = 4;
  localparam int SECOND_GRP_BASE = 2;

  // interrupt status bits
  localparam int IRQ_CORE  = 0;
  localparam int IRQ_LAUX  = 1;
  localparam int IRQ_UAUX  = 2;
  localparam int IRQ_CBASE = 3;
  localparam int IRQ_MAST  = 4;
  localparam int IRQ_CAP   = 5;
  localparam int IRQ_W     = 6;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] CNT_RESET  = 16'h0000;

  typedef logic [15:0] gtu_cnt_t;

endpackage : gtu_pkg

// ### gtu_top.sv
// general timer unit: two timer groups with toggle latches, capture and reload
// assumes apb master on clk_sys; all pins asynchronous and synchronised here
//
// How it works
// - five 16-bit timers, groups of three and two
// - first group timers select four basic modes
// - timer mode uses prescaled clock, counter counts pin
// - gated mode counts only at gate level
// - first group finest step is 4 clocks
// - software direction, optionally flipped by pin
// - incremental mode decodes quadrature on two pins
// - core latch toggles on wrap, clocks aux timers
// - aux in capture or reload stops counting
// - capture copies core into aux on pin
// - reload loads core from aux on trigger
// - opposite latch edges alternate two reload values
// - second group finest step is 2 clocks
// - second group uses prescaler or external pins
// - master latch toggles on wrap, clocks capture base
// - master wraps clock capcom, may reload master
// - capture pin latches capture base, optional clear
// - core input or direction pins also capture
`timescale 1ns/1ps
`default_nettype none
module gtu_top
  import gtu_pkg::*;
(
  input  wire logic        clk_sys,        // system clock 250 mhz
  input  wire logic        sys_rst,        // synchronous reset, high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic             pready,         // apb ready
  output logic      [31:0] prdata,         // apb read data
  output logic             pslverr,        // apb error for unmapped
  input  wire logic [4:0]  timer_in_pin,   // per timer input pins
  input  wire logic [4:0]  dir_in_pin,     // per timer direction pins
  input  wire logic        capture_input_pin, // capture pin
  output logic             core_toggle_output,   // core latch pin
  output logic             master_toggle_output, // master latch pin
  output logic             capcom_clk_en,  // master wrap pulse for capcom timers
  output logic             irq             // interrupt level
);

  localparam int NT = 5; // 0 core, 1 lower aux, 2 upper aux, 3 capture base, 4 master

  // all state is one packed struct:
  // the comb process builds st_next
  // from st_reg, one flop stage
  // commits it on every clock edge

  typedef struct packed {
    logic [NT-1:0][31:0] ctrl;
    logic [NT-1:0][15:0] cnt;
    logic [15:0]         capture_reload_reg;
    logic [NT-1:0][1:0]  tin_s;
    logic [NT-1:0][1:0]  dir_s;
    logic [NT-1:0]       tin_d;
    logic [NT-1:0]       dir_d;
    logic [1:0]          cap_s;
    logic                cap_d;
    logic [9:0]          pre;
    logic                core_tl;
    logic                mast_tl;
    logic [IRQ_W-1:0]    sts;
    logic [IRQ_W-1:0]    msk;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic                core_out;
    logic                mast_out;
    logic                capcom;
    logic                irq;
  } gtu_state_t;

  gtu_state_t st_reg;
  gtu_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // both helpers are pure functions,
  // so each timer slot reuses them
  // without extra state of its own
  // and with no hidden registers

  // edge selected by two bits: bit0 rising, bit1 falling
  function automatic logic edge_hit(input logic now, input logic old, input logic [1:0] sel);
    edge_hit = (sel[0] & now & ~old) | (sel[1] & ~now & old);
  endfunction

  // prescaler tick: base step times 2**exp, taken from free counter
  function automatic logic pre_tick(input logic [9:0] pre, input logic [2:0] ex,
                                    input int base);
    logic [9:0] m;
    m = 10'((base << ex) - 1);
    pre_tick = ((pre & m) == m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [NT-1:0]      step;
    logic [NT-1:0]      down;
    logic [NT-1:0]      wrap;
    logic [NT-1:0]      tin_e;
    logic [NT-1:0]      dir_e;
    logic [2:0]         md;
    logic [1:0]         es;
    logic               core_tl_rise;
    logic               core_tl_fall;
    logic               mast_wrap;
    logic               cap_trig;
    logic [IRQ_W-1:0]   ev;
    logic               acc;
    logic               wr;
    logic [31:0]        rd;
    logic               hit;
    step = '0;
    down = '0;
    wrap = '0;
    tin_e = '0;
    dir_e = '0;
    md = MODE_TIMER;
    es = 2'b00;
    ev = '0;
    rd = 32'h0000_0000;
    hit = 1'b0;
    core_tl_rise = 1'b0;
    core_tl_fall = 1'b0;
    mast_wrap = 1'b0;
    cap_trig = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    st_next = st_reg;


    // pins are asynchronous: logic
    // reads only the second stage,
    // the third flop is the history
    // for edge detection
    // pin synchronisers, second stage only is read
    st_next.cap_s = {st_reg.cap_s[0], capture_input_pin};
    st_next.cap_d = st_reg.cap_s[1];
    for (int i = 0; i < NT; i++) begin
      st_next.tin_s[i] = {st_reg.tin_s[i][0], timer_in_pin[i]};
      st_next.dir_s[i] = {st_reg.dir_s[i][0], dir_in_pin[i]};
      st_next.tin_d[i] = st_reg.tin_s[i][1];
      st_next.dir_d[i] = st_reg.dir_s[i][1];
      tin_e[i] = st_reg.tin_s[i][1] ^ st_reg.tin_d[i];
      dir_e[i] = st_reg.dir_s[i][1] ^ st_reg.dir_d[i];
    end
    st_next.pre = st_reg.pre + 10'h001;


    // a stopped timer never steps;
    // capture and reload aux modes
    // fall to the default branch
    // so the aux value stands still
    // first group: step and direction per timer
    for (int i = 0; i < 3; i++) begin
      md = st_reg.ctrl[i][CTL_MODE_L +: 3];
      es = st_reg.ctrl[i][CTL_EDGE_L +: 2];
      down[i] = st_reg.ctrl[i][CTL_DOWN] ^
                (st_reg.ctrl[i][CTL_EXTDIR] & st_reg.dir_s[i][1]);
      if (st_reg.ctrl[i][CTL_RUN]) begin
        case (md)
          MODE_TIMER:
            step[i] = pre_tick(st_reg.pre, st_reg.ctrl[i][CTL_PRE_L +: 3],
                               FIRST_GRP_BASE);
          MODE_GATED:
            step[i] = pre_tick(st_reg.pre, st_reg.ctrl[i][CTL_PRE_L +: 3], FIRST_GRP_BASE)
                      & (st_reg.tin_s[i][1] == st_reg.ctrl[i][CTL_GATEHI]);
          MODE_COUNTER:
            step[i] = edge_hit(st_reg.tin_s[i][1], st_reg.tin_d[i], es);
          MODE_INCR: begin
            // quadrature: any edge of either signal is a step
            step[i] = tin_e[i] | dir_e[i];
            down[i] = tin_e[i] ? (st_reg.tin_s[i][1] == st_reg.dir_s[i][1])
                               : (st_reg.tin_s[i][1] != st_reg.dir_s[i][1]);
            down[i] = down[i] ^ st_reg.ctrl[i][CTL_DOWN];
          end
          default: step[i] = 1'b0;
        endcase
      end
    end
    wrap[0] = step[0] & (down[0] ? st_reg.cnt[0] == 16'h0000
                                 : st_reg.cnt[0] == 16'hFFFF);
    core_tl_rise = wrap[0] & ~st_reg.core_tl;
    core_tl_fall = wrap[0] & st_reg.core_tl;
    if (wrap[0]) st_next.core_tl = ~st_reg.core_tl;

    // latch-clocked aux timers use
    // the edge select bits to pick
    // core latch rise, fall or both
    // for long period measurement
    // aux timers clocked by core latch transitions
    for (int i = 1; i < 3; i++) begin
      if (st_reg.ctrl[i][CTL_RUN] && st_reg.ctrl[i][CTL_MODE_L +: 3] == MODE_LATCHCK)
        step[i] = edge_hit(~st_reg.core_tl, st_reg.core_tl, {core_tl_fall, core_tl_rise}
                           & st_reg.ctrl[i][CTL_EDGE_L +: 2]) | 1'b0;
    end


    // gated and incremental modes
    // are not offered here, so they
    // leave the timer stopped
    // rather than counting wrongly
    // second group
    for (int i = 3; i < NT; i++) begin
      md = st_reg.ctrl[i][CTL_MODE_L +: 3];
      es = st_reg.ctrl[i][CTL_EDGE_L +: 2];
      down[i] = st_reg.ctrl[i][CTL_DOWN] ^
                (st_reg.ctrl[i][CTL_EXTDIR] & st_reg.dir_s[i][1]);
      if (st_reg.ctrl[i][CTL_RUN]) begin
        case (md)
          MODE_TIMER:
            step[i] = pre_tick(st_reg.pre, st_reg.ctrl[i][CTL_PRE_L +: 3],
                               SECOND_GRP_BASE);
          MODE_COUNTER:
            step[i] = edge_hit(st_reg.tin_s[i][1], st_reg.tin_d[i], es);
          default: step[i] = 1'b0;
        endcase
      end
    end
    mast_wrap = step[4] & (down[4] ? st_reg.cnt[4] == 16'h0000
                                   : st_reg.cnt[4] == 16'hFFFF);
    wrap[4] = mast_wrap;
    if (mast_wrap) st_next.mast_tl = ~st_reg.mast_tl;
    if (st_reg.ctrl[3][CTL_RUN] && st_reg.ctrl[3][CTL_MODE_L +: 3] == MODE_LATCHCK)
      step[3] = mast_wrap;
    for (int i = 1; i < 4; i++)
      wrap[i] = step[i] & (down[i] ? st_reg.cnt[i] == 16'h0000
                                   : st_reg.cnt[i] == 16'hFFFF);


    // later writes below override
    // the count step: reload,
    // capture and apb writes win
    // over a step in one cycle
    // counting, wrap at both ends by modular arithmetic
    for (int i = 0; i < NT; i++) begin
      if (step[i])
        st_next.cnt[i] = down[i] ? st_reg.cnt[i] - 16'h0001
                                 : st_reg.cnt[i] + 16'h0001;
    end


    // the reload replaces the wrap
    // value, so the master period
    // is set by the capture_reload_reg word
    // without software action
    // master reload from capture/reload register
    if (mast_wrap && st_reg.ctrl[4][CTL_RLTOG])
      st_next.cnt[4] = st_reg.capture_reload_reg;


    // two aux timers set to reload
    // on opposite latch edges give
    // alternating high and low times
    // for a free running pwm
    // aux capture and reload links to the core timer
    for (int i = 1; i < 3; i++) begin
      es = st_reg.ctrl[i][CTL_EDGE_L +: 2];
      if (st_reg.ctrl[i][CTL_MODE_L +: 3] == MODE_CAPTURE &&
          edge_hit(st_reg.tin_s[i][1], st_reg.tin_d[i], es)) begin
        st_next.cnt[i] = st_reg.cnt[0];
        ev[i] = 1'b1;
      end
      if (st_reg.ctrl[i][CTL_MODE_L +: 3] == MODE_RELOAD &&
          (edge_hit(st_reg.tin_s[i][1], st_reg.tin_d[i], es) ||
           (core_tl_rise && st_reg.ctrl[i][CTL_GATEHI]) ||
           (core_tl_fall && st_reg.ctrl[i][CTL_CLRCB])))
        st_next.cnt[0] = st_reg.cnt[i];
    end


    // core pin edges can also fire
    // the capture, useful when the
    // core decodes a position sensor
    // in incremental mode
    // capture base into capture/reload register
    cap_trig = edge_hit(st_reg.cap_s[1], st_reg.cap_d, st_reg.ctrl[3][CTL_EDGE_L +: 2])
             | (st_reg.ctrl[3][CTL_CAPSRC] & tin_e[0])
             | (st_reg.ctrl[3][CTL_CAPSRC + 1] & dir_e[0]);
    if (cap_trig) begin
      st_next.capture_reload_reg = st_reg.cnt[3];
      if (st_reg.ctrl[3][CTL_CLRCB])
        st_next.cnt[3] = CNT_RESET;
    end

    ev[IRQ_CORE] = wrap[0];
    ev[IRQ_LAUX] = ev[IRQ_LAUX] | wrap[1];
    ev[IRQ_UAUX] = ev[IRQ_UAUX] | wrap[2];
    ev[IRQ_CBASE] = wrap[3];
    ev[IRQ_MAST] = wrap[4];
    ev[IRQ_CAP] = cap_trig;


    // read data is picked at setup
    // and registered, so it stands
    // with pready in the access cycle
    // refused writes change nothing
    // apb slave, zero wait states
    acc = psel & penable;
    wr = acc & pwrite;
    st_next.pready = psel & ~penable;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      hit = 1'b1;
      for (int i = 0; i < NT; i++) begin
        if (paddr == OFS_CORE_CTRL + 8'(4 * i)) rd = st_reg.ctrl[i];
        else if (paddr == OFS_CORE_CNT + 8'(4 * i)) rd = {16'h0000, st_reg.cnt[i]};
      end
      if (paddr == OFS_CAPTURE_RELOAD_REG) rd = {16'h0000, st_reg.capture_reload_reg};
      else if (paddr == OFS_IRQ_STATUS) rd = {26'h0, st_reg.sts};
      else if (paddr == OFS_IRQ_MASK) rd = {26'h0, st_reg.msk};
      else if (paddr == OFS_LATCH) rd = {30'h0, st_reg.mast_tl, st_reg.core_tl};
      else if (paddr > OFS_LATCH || paddr[1:0] != 2'b00) hit = 1'b0;
      st_next.prdata = rd;
      st_next.pslverr = ~hit;
    end
    if (wr && !st_reg.pslverr) begin
      for (int i = 0; i < NT; i++) begin
        if (paddr == OFS_CORE_CTRL + 8'(4 * i)) st_next.ctrl[i] = pwdata;
        else if (paddr == OFS_CORE_CNT + 8'(4 * i)) st_next.cnt[i] = pwdata[15:0];
      end
      if (paddr == OFS_CAPTURE_RELOAD_REG) st_next.capture_reload_reg = pwdata[15:0];
      else if (paddr == OFS_IRQ_MASK) st_next.msk = pwdata[IRQ_W-1:0];
    end


    // an event in the same cycle as
    // its clear must not be lost,
    // so events are ored in last
    // after the clear is applied
    // sticky status: set wins over write-one-to-clear
    if (wr && !st_reg.pslverr && paddr == OFS_IRQ_STATUS)
      st_next.sts = st_reg.sts & ~pwdata[IRQ_W-1:0];
    st_next.sts = st_next.sts | ev;

    st_next.core_out = st_next.core_tl & st_reg.ctrl[0][CTL_OUTEN];
    st_next.mast_out = st_next.mast_tl & st_reg.ctrl[4][CTL_OUTEN];
    st_next.capcom = mast_wrap;
    st_next.irq = |(st_next.sts & st_next.msk);

    if (sys_rst) begin
      st_next = '0;
      st_next.ctrl = {NT{CTRL_RESET}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset is folded into st_next,
  // so this flop stage is plain
  // and every output is a flop
  // with no logic after it
  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end


  // plain wires from the struct,
  // no gates between flop and pin
  // outputs straight from flip-flops
  assign pready = st_reg.pready;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign core_toggle_output = st_reg.core_out;
  assign master_toggle_output = st_reg.mast_out;
  assign capcom_clk_en = st_reg.capcom;
  assign irq = st_reg.irq;

endmodule // gtu_top
`default_nettype wire
